// *** fxad_decoder.sv ***
// Extended-address decoder: serial opcode and address capture with APB bank register
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "fxad_defines.svh"

module fxad_decoder
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic data_byte_done,
    output logic addr_valid,
    output logic addr_four_byte,
    output logic [7:0] opcode_out,
    output logic [31:0] start_addr,
    output logic [31:0] cur_addr,
    output fxad_pkg::fxad_state_t seq_state
);
    import fxad_pkg::*;

    // -----------------------------------------------------------------------
    // Opcode classification
    // -----------------------------------------------------------------------

    // Sorts an opcode by how its address field is sized
    function automatic fxad_class_t op_class(input logic [7:0] op);
        fxad_class_t c;
        c = FXAD_CLS_NONE;
        unique case (op)
            8'h13, 8'h0c, 8'hbc, 8'h3c, 8'hec, 8'h6c, 8'h0e, 8'hbe, 8'hee,
            8'h12, 8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc, 8'h25,
            8'he0, 8'he1, 8'he2, 8'he3:
                c = FXAD_CLS_ALWAYS4; // see R10 see R11 see R12 see R13 see R14 see R15 see R16
            8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed,
            8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'h26,
            8'hfa, 8'hfb, 8'hfc, 8'hfd:
                c = FXAD_CLS_FLAGDEP; // see R17 see R18 see R19 see R20
            `FXAD_OP_ENTER4:
                c = FXAD_CLS_ENTER4;
            `FXAD_OP_EXIT4:
                c = FXAD_CLS_EXIT4;
            default:
                c = FXAD_CLS_NONE;
        endcase
        return c;
    endfunction

    // Array reads that stream data and advance the address
    function automatic logic op_is_read(input logic [7:0] op);
        logic r;
        r = 1'b0;
        unique case (op)
            8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed,
            8'h13, 8'h0c, 8'hbc, 8'h3c, 8'hec, 8'h6c, 8'h0e, 8'hbe, 8'hee:
                r = 1'b1;
            default:
                r = 1'b0;
        endcase
        return r;
    endfunction

    // -----------------------------------------------------------------------
    // Link synchronisers
    // -----------------------------------------------------------------------

    logic cs_n_s1_reg, cs_n_s2_reg;
    logic sck_s1_reg, sck_s2_reg, sck_prev_reg;
    logic si_s1_reg, si_s2_reg;
    logic sck_rise;

    // Two flops per pin; select idles high so reset looks deselected
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
            si_s1_reg <= 1'b0;
            si_s2_reg <= 1'b0;
        end
        else
        begin
            cs_n_s1_reg <= cs_n;
            cs_n_s2_reg <= cs_n_s1_reg;
            sck_s1_reg <= sck;
            sck_s2_reg <= sck_s1_reg;
            sck_prev_reg <= sck_s2_reg;
            si_s1_reg <= si;
            si_s2_reg <= si_s1_reg;
        end
    end

    // Edge found on synchronised copies only; link clock must stay under pclk/4
    assign sck_rise = sck_s2_reg & ~sck_prev_reg;

    // -----------------------------------------------------------------------
    // Serial command sequencer
    // -----------------------------------------------------------------------

    fxad_state_t state_reg, state_next;
    logic [5:0] bit_cnt_reg, bit_cnt_next;
    logic [31:0] shift_reg, shift_next;
    logic [7:0] opcode_reg, opcode_next;
    logic four_reg, four_next;
    logic enter4_reg, enter4_next;
    logic read_cmd_reg, read_cmd_next;
    logic addr_valid_reg, addr_valid_next;
    logic [31:0] start_addr_reg, start_addr_next;
    logic [31:0] cur_addr_reg, cur_addr_next;
    logic [7:0] bank_reg, bank_next;
    logic [7:0] op_in;
    logic [31:0] addr_in;
    fxad_class_t cls_in;

    // Bits arrive most significant first, so each shifts in at the bottom
    assign op_in = {shift_reg[6:0], si_s2_reg}; // see R22
    assign addr_in = {shift_reg[30:0], si_s2_reg};
    assign cls_in = op_class(op_in);

    // Next-state logic; deselect aborts any command at once
    always_comb
    begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        opcode_next = opcode_reg;
        four_next = four_reg;
        enter4_next = enter4_reg;
        read_cmd_next = read_cmd_reg;
        addr_valid_next = 1'b0;
        start_addr_next = start_addr_reg;
        cur_addr_next = cur_addr_reg;
        if (cs_n_s2_reg)
        begin
            state_next = FXAD_IDLE;
        end
        else
        begin
            unique case (state_reg)
                FXAD_IDLE:
                begin
                    state_next = FXAD_OPCODE;
                    bit_cnt_next = 6'h00;
                    if (sck_rise)
                    begin
                        shift_next = {31'h00000000, si_s2_reg};
                        bit_cnt_next = 6'h01;
                    end
                end
                FXAD_OPCODE:
                begin
                    if (sck_rise)
                    begin
                        shift_next = addr_in;
                        bit_cnt_next = bit_cnt_reg + 6'h01;
                        if (bit_cnt_reg == 6'h07)
                        begin
                            opcode_next = op_in;
                            read_cmd_next = op_is_read(op_in);
                            bit_cnt_next = 6'h00;
                            state_next = FXAD_ADDR;
                            unique case (cls_in)
                                FXAD_CLS_ALWAYS4:
                                    four_next = 1'b1; // see R10 see R14 see R15 see R16
                                FXAD_CLS_FLAGDEP:
                                    four_next = bank_reg[`FXAD_EXT_FLAG_BIT] | enter4_reg; // see R1 see R2 see R17
                                FXAD_CLS_ENTER4:
                                begin
                                    // Mode command only counts while the flag is clear
                                    if (!bank_reg[`FXAD_EXT_FLAG_BIT])
                                    begin
                                        enter4_next = 1'b1; // see R2
                                    end
                                    state_next = FXAD_DONE;
                                end
                                FXAD_CLS_EXIT4:
                                begin
                                    enter4_next = 1'b0;
                                    state_next = FXAD_DONE;
                                end
                                default:
                                    state_next = FXAD_DONE;
                            endcase
                        end
                    end
                end
                FXAD_ADDR:
                begin
                    if (sck_rise)
                    begin
                        shift_next = addr_in;
                        bit_cnt_next = bit_cnt_reg + 6'h01;
                        if (bit_cnt_next == (four_reg ? `FXAD_ADDR4_BITS : `FXAD_ADDR3_BITS))
                        begin
                            // Bank byte over the 24 received bits in three-byte mode
                            start_addr_next = four_reg ? addr_in
                                : {bank_reg, addr_in[23:0]}; // see R3 see R4 see R5 see R9 see R23
                            cur_addr_next = start_addr_next;
                            addr_valid_next = 1'b1;
                            state_next = FXAD_DATA;
                        end
                    end
                end
                FXAD_DATA:
                begin
                    // Bank byte is not consulted here: streaming runs past bank ends
                    if (data_byte_done && read_cmd_reg && cur_addr_reg != `FXAD_ARRAY_LAST)
                    begin
                        cur_addr_next = cur_addr_reg + 32'h00000001; // see R7 see R8
                    end
                end
                FXAD_DONE:
                begin
                    state_next = FXAD_DONE;
                end
            endcase
        end
    end

    // Sequencer registers; power-up leaves three-byte mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= FXAD_IDLE;
            bit_cnt_reg <= 6'h00;
            shift_reg <= 32'h00000000;
            opcode_reg <= 8'h00;
            four_reg <= 1'b0;
            enter4_reg <= 1'b0;
            read_cmd_reg <= 1'b0;
            addr_valid_reg <= 1'b0;
            start_addr_reg <= 32'h00000000;
            cur_addr_reg <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            opcode_reg <= opcode_next;
            four_reg <= four_next;
            enter4_reg <= enter4_next;
            read_cmd_reg <= read_cmd_next;
            addr_valid_reg <= addr_valid_next;
            start_addr_reg <= start_addr_next;
            cur_addr_reg <= cur_addr_next;
        end
    end

    // -----------------------------------------------------------------------
    // APB register slave
    // -----------------------------------------------------------------------

    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic mapped;
    logic wr_take;

    // One wait state: ready rises on the second access cycle
    assign wr_take = psel & penable & pready_reg & pwrite;
    assign mapped = (paddr == `FXAD_OFS_BANK) || (paddr == `FXAD_OFS_MODE) ||
                    (paddr == `FXAD_OFS_START) || (paddr == `FXAD_OFS_OPCODE) ||
                    (paddr == `FXAD_OFS_CUR);

    // Answer, read mux and bank write; only software alters the bank
    always_comb
    begin
        pready_next = psel & penable & ~pready_reg;
        pslverr_next = psel & penable & ~pready_reg & ~mapped;
        prdata_next = 32'h00000000;
        bank_next = bank_reg;
        if (psel && penable && !pready_reg && !pwrite)
        begin
            unique case (paddr)
                `FXAD_OFS_BANK: prdata_next = {24'h000000, bank_reg};
                `FXAD_OFS_MODE: prdata_next = {29'h00000000, read_cmd_reg, enter4_reg,
                                               bank_reg[`FXAD_EXT_FLAG_BIT] | enter4_reg};
                `FXAD_OFS_START: prdata_next = start_addr_reg;
                `FXAD_OFS_OPCODE: prdata_next = {24'h000000, opcode_reg};
                `FXAD_OFS_CUR: prdata_next = cur_addr_reg;
                default: prdata_next = 32'h00000000;
            endcase
        end
        if (wr_take && paddr == `FXAD_OFS_BANK)
        begin
            bank_next = pwdata[7:0]; // see R21
        end
    end

    // Bank register is volatile: reset brings bank zero, flag clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bank_reg <= `FXAD_BANK_RESET; // see R6
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            bank_reg <= bank_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign addr_valid = addr_valid_reg;
    assign addr_four_byte = four_reg;
    assign opcode_out = opcode_reg;
    assign start_addr = start_addr_reg;
    assign cur_addr = cur_addr_reg;
    assign seq_state = state_reg;

    // -----------------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------------

    logic op_done;
    assign op_done = (state_reg == FXAD_OPCODE) && sck_rise && (bit_cnt_reg == 6'h07) && !cs_n_s2_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_flag_widens: assert property ( // see R1
        op_done && cls_in == FXAD_CLS_FLAGDEP && bank_reg[7] |=> four_reg && state_reg == FXAD_ADDR)
        else $error("flag-dependent opcode not widened with flag set");

    chk_enter_mode: assert property ( // see R2
        op_done && cls_in == FXAD_CLS_ENTER4 && !bank_reg[7] ##1 (state_reg != FXAD_IDLE)[*2]
        |-> enter4_reg)
        else $error("enter command did not switch to four-byte mode");

    chk_always_four: assert property ( // see R10
        op_done && cls_in == FXAD_CLS_ALWAYS4 |=> four_reg)
        else $error("four-byte opcode decoded as three-byte");

    chk_flag_narrow: assert property ( // see R17
        op_done && cls_in == FXAD_CLS_FLAGDEP && !bank_reg[7] && !enter4_reg |=> !four_reg)
        else $error("flag-dependent opcode widened with flag clear");

    chk_bank_upper: assert property ( // see R23
        addr_valid_reg && !four_reg |-> start_addr_reg[31:24] == $past(bank_reg))
        else $error("three-byte start address lacks bank byte");

    chk_bank_one_base: assert property ( // see R9
        addr_valid_reg && !four_reg && $past(bank_reg) == 8'h01 |-> start_addr_reg[31:24] == 8'h01)
        else $error("bank one does not map from 01000000h");

    chk_stream_step: assert property ( // see R7
        state_reg == FXAD_DATA && !cs_n_s2_reg && data_byte_done && read_cmd_reg
        && cur_addr_reg != 32'h01ffffff |=> cur_addr_reg == $past(cur_addr_reg) + 32'h00000001)
        else $error("read stream did not advance in one cycle");

    chk_bank_steady: assert property ( // see R8
        state_reg == FXAD_DATA && !wr_take |=> $stable(bank_reg))
        else $error("bank register changed during streaming");

    chk_apb_answer: assert property (
        psel && penable && !pready_reg |=> pready_reg ##1 !pready_reg)
        else $error("APB answer not one cycle after access");

    cov_three_byte: cover property (addr_valid_reg && !four_reg && start_addr_reg[24]);
    cov_four_byte: cover property (addr_valid_reg && four_reg);
    cov_enter: cover property (op_done && cls_in == FXAD_CLS_ENTER4);
    cov_cross_bank: cover property (state_reg == FXAD_DATA && cur_addr_reg == 32'h00ffffff ##[1:400]
        cur_addr_reg == 32'h01000000);

endmodule

// *** fxad_decoder_bench.sv ***
// Self-checking bench for the extended-address decoder
`timescale 1ns/10ps
`include "fxad_defines.svh"

module fxad_decoder_bench;
    import fxad_pkg::*;

    logic pclk, presetn, psel, penable, pwrite, data_byte_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, start_addr, cur_addr;
    logic pready, pslverr, cs_n, sck, si, addr_valid, addr_four_byte;
    logic [7:0] opcode_out;
    fxad_state_t seq_state;
    int error_cnt = 0;
    int tests_run = 0;
    int valid_cnt = 0;
    logic [31:0] seed = 32'h0000003f;
    logic [31:0] a, q, ex;
    logic [7:0] bank;
    logic e;
    int i, k;
    logic [7:0] op4 [20] = '{8'h13, 8'h0c, 8'hbc, 8'h3c, 8'hec, 8'h6c, 8'h0e, 8'hbe, 8'hee, 8'h12,
        8'h34, 8'h3e, 8'h21, 8'h5c, 8'hdc, 8'h25, 8'he0, 8'he1, 8'he2, 8'he3};
    logic [7:0] opf [21] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h0d, 8'hbd, 8'hed, 8'h02,
        8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'h26, 8'hfa, 8'hfb, 8'hfc, 8'hfd};

    fxad_decoder u_fxad_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .sck(sck), .si(si), .data_byte_done(data_byte_done),
        .addr_valid(addr_valid), .addr_four_byte(addr_four_byte), .opcode_out(opcode_out),
        .start_addr(start_addr), .cur_addr(cur_addr), .seq_state(seq_state));

    fxad_host_model u_fxad_host_model (.cs_n(cs_n), .sck(sck), .si(si));

    // 250 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Count address-complete pulses so a missing or doubled one shows
    always @(posedge pclk)
    begin
        if (addr_valid === 1'b1)
            valid_cnt <= valid_cnt + 1;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Three-byte mode puts the whole bank byte on top of the 24 bits
    function automatic logic [31:0] exp_start(input logic [7:0] b, input logic four, input logic [31:0] ad);
        return four ? ad : {b, ad[23:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; waits for pready under a bounded count
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] rd,
        output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            check(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Send one whole command; checks only apply when an address field follows
    task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input int nbits, input logic [31:0] exp_s);
        int v0;
        v0 = valid_cnt;
        u_fxad_host_model.frame_open(op, ad, nbits);
        u_fxad_host_model.frame_close();
        repeat (4) @(posedge pclk);
        if (nbits > 0)
        begin
            check(32'(valid_cnt - v0), 32'h1);
            check(start_addr, exp_s);
            check({31'h0, addr_four_byte}, {31'h0, nbits == 32});
            check({24'h0, opcode_out}, {24'h0, op});
        end
    endtask

    task automatic pulse_data(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            data_byte_done <= 1'b1;
            @(posedge pclk);
            data_byte_done <= 1'b0;
        end
        repeat (2) @(posedge pclk);
    endtask

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, data_byte_done} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `FXAD_OFS_BANK, 0, q, e);
        check(q, 32'h0);
        apb(0, 8'h14, 0, q, e);
        check({31'h0, e}, 32'h1);
        apb(1, `FXAD_OFS_BANK, 32'h81, q, e);
        apb(0, `FXAD_OFS_BANK, 0, q, e);
        check(q, 32'h81);
        // Dedicated four-byte opcodes ignore the flag and the bank
        foreach (op4[i])
        begin
            bank = rnd() & 8'h81;
            a = rnd();
            apb(1, `FXAD_OFS_BANK, {24'h0, bank}, q, e);
            cmd(op4[i], a, 32, a);
        end
        // Flag-sized opcodes with the flag clear then set, random bank
        for (k = 0; k < 2; k++)
        begin
            foreach (opf[i])
            begin
                // Draw the bank bit alone so the flag bit is not lost to truncation
                q = rnd();
                bank = {k[0], 6'h00, q[0]};
                a = rnd();
                apb(1, `FXAD_OFS_BANK, {24'h0, bank}, q, e);
                cmd(opf[i], a, k ? 32 : 24, exp_start(bank, k[0], a));
            end
        end
        // Read-only start register ignores a write
        apb(1, `FXAD_OFS_START, rnd(), q, e);
        apb(0, `FXAD_OFS_START, 0, q, e);
        check(q, exp_start(bank, 1'b1, a));
        // Enter-four-byte with the flag clear, then leave again
        apb(1, `FXAD_OFS_BANK, 32'h01, q, e);
        cmd(`FXAD_OP_ENTER4, 0, 0, 0);
        apb(0, `FXAD_OFS_MODE, 0, q, e);
        check(q & 32'h3, 32'h3);
        a = rnd();
        cmd(8'h03, a, 32, a);
        cmd(`FXAD_OP_EXIT4, 0, 0, 0);
        cmd(8'h03, a, 24, {8'h01, a[23:0]});
        // Stream across the bank boundary; bank register stays
        apb(1, `FXAD_OFS_BANK, 32'h00, q, e);
        u_fxad_host_model.frame_open(8'h03, 32'h00fffffe, 24);
        repeat (4) @(posedge pclk);
        check(cur_addr, 32'h00fffffe);
        check({27'h0, seq_state}, 32'h08);
        pulse_data(3);
        check(cur_addr, 32'h01000001);
        u_fxad_host_model.frame_close();
        apb(0, `FXAD_OFS_BANK, 0, q, e);
        check(q, 32'h0);
        // Stream stops at the last byte of the array
        apb(1, `FXAD_OFS_BANK, 32'h01, q, e);
        u_fxad_host_model.frame_open(8'h0b, 32'h00fffffe, 24);
        pulse_data(3);
        check(cur_addr, `FXAD_ARRAY_LAST);
        u_fxad_host_model.frame_close();
        apb(0, `FXAD_OFS_BANK, 0, q, e);
        check(q, 32'h01);
        // Unknown opcode takes no address field and parks until deselect
        k = valid_cnt;
        u_fxad_host_model.frame_open(8'h05, 0, 0);
        repeat (4) @(posedge pclk);
        check({27'h0, seq_state}, 32'h10);
        check({24'h0, opcode_out}, 32'h05);
        u_fxad_host_model.frame_close();
        check(32'(valid_cnt - k), 32'h0);
        check({27'h0, seq_state}, 32'h01);
        // Mid-run reset: bank byte and enter-four-byte latch are both volatile
        apb(1, `FXAD_OFS_BANK, 32'h01, q, e);
        cmd(`FXAD_OP_ENTER4, 0, 0, 0);
        apb(1, `FXAD_OFS_BANK, 32'h81, q, e);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `FXAD_OFS_BANK, 0, q, e);
        check(q, 32'h0);
        apb(0, `FXAD_OFS_MODE, 0, q, e);
        check(q, 32'h0);
        a = rnd();
        cmd(8'h03, a, 24, {8'h00, a[23:0]});
        give_verdict();
    end

    // Watchdog: the sequence needs about 175 us, so 300 us means a hang
    initial
    begin
        #300000;
        error_cnt++;
        give_verdict();
    end

endmodule

// *** fxad_defines.svh ***
// Constants for the extended-address decoder: register map, fields, opcodes
// ---------------------------------------------------------------------------
// Behaviour
// R1 - Flag set: standard opcodes take 32-bit address
// R2 - Enter-4-byte command with flag clear widens too
// R3 - Three-byte mode takes top byte from bank
// R4 - Banks span 16 MB, 24 bits address within
// R5 - Bank applies to read, program and erase
// R6 - Bank register volatile, resets to bank zero
// R7 - Reads stream across banks without extra delay
// R8 - Crossing reads never modify the bank register
// R9 - Bank bit 0 selects 00000000h or 01000000h
// R10 - Opcodes 13h, 0Ch always take 32-bit address
// R11 - Opcodes BCh, 3Ch always take 32-bit address
// R12 - Opcodes ECh, 6Ch always take 32-bit address
// R13 - Opcodes 0Eh, BEh, EEh always 32-bit address
// R14 - Opcodes 12h, 34h, 3Eh always 32-bit address
// R15 - Opcodes 21h, 5Ch, DCh always 32-bit address
// R16 - Opcodes 25h, E0 to E3 always 32-bit
// R17 - 03h, 0Bh, BBh width follows the flag
// R18 - 3Bh, EBh, 6Bh width follows the flag
// R19 - 0Dh, BDh, EDh width follows the flag
// R20 - 02h, 32h, 38h width follows the flag
// R21 - Host writes bank before reaching upper banks
// R22 - Host sends everything most significant first
// R23 - Three-byte address is bank byte over 24 bits
// ---------------------------------------------------------------------------
`ifndef FXAD_DEFINES_SVH
`define FXAD_DEFINES_SVH

// APB register byte offsets
`define FXAD_OFS_BANK 8'h00
`define FXAD_OFS_MODE 8'h04
`define FXAD_OFS_START 8'h08
`define FXAD_OFS_OPCODE 8'h0c
`define FXAD_OFS_CUR 8'h10

// Bank register fields and reset value
`define FXAD_BANK_RESET 8'h00
`define FXAD_EXT_FLAG_BIT 7
`define FXAD_BANK_SEL_BIT 0

// Address widths in bits and last byte of the array
`define FXAD_ADDR3_BITS 6'h18
`define FXAD_ADDR4_BITS 6'h20
`define FXAD_ARRAY_LAST 32'h01ffffff

// Mode enter and exit opcodes
`define FXAD_OP_ENTER4 8'hb7
`define FXAD_OP_EXIT4 8'he9

`endif

// *** fxad_host_model.sv ***
// Host serial controller model: drives select, clock and data lanes
`timescale 1ns/10ps

module fxad_host_model
(
    output logic cs_n,
    output logic sck,
    output logic si
);

    // Idle: deselected, clock parked low between frames
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b1;
    end

    // Select, then shift opcode and nbits of address, 64 ns clock period
    task automatic frame_open(input logic [7:0] op, input logic [31:0] addr, input int nbits);
        logic [39:0] word;
        int i;
        word = (nbits == 24) ? {op, addr[23:0], 8'h00} : {op, addr};
        cs_n = 1'b0;
        #21;
        for (i = 0; i < 8 + nbits; i++)
        begin
            si = word[39];
            word = word << 1;
            #32 sck = 1'b1;
            #32 sck = 1'b0;
        end
    endtask

    // Deselect; the released data lane shows the inverse of its last bit
    task automatic frame_close();
        #40 cs_n = 1'b1;
        si = ~si;
        #100;
    endtask

endmodule

// *** fxad_pkg.sv ***
// Types shared by the extended-address decoder
package fxad_pkg;

    // Serial command sequencer states, one-hot
    typedef enum logic [4:0] {
        FXAD_IDLE = 5'h01,
        FXAD_OPCODE = 5'h02,
        FXAD_ADDR = 5'h04,
        FXAD_DATA = 5'h08,
        FXAD_DONE = 5'h10
    } fxad_state_t;

    // How an opcode sizes its address field
    typedef enum logic [2:0] {
        FXAD_CLS_NONE = 3'h0,
        FXAD_CLS_ALWAYS4 = 3'h1,
        FXAD_CLS_FLAGDEP = 3'h2,
        FXAD_CLS_ENTER4 = 3'h3,
        FXAD_CLS_EXIT4 = 3'h4
    } fxad_class_t;

endpackage
